/* File: core/cod_pkg.sv */
// Purpose: Shared constants and types for the clock option decoder.
// Assumes: 32-bit APB register words, one aligned word per register.
// Notes:   Option byte bit positions and register offsets live here only.
`default_nettype none

package cod_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] COD_ADDR_CLK_OPT  = 8'h00;
  localparam logic [7:0] COD_ADDR_SETTLE   = 8'h04;
  localparam logic [7:0] COD_ADDR_CTRL     = 8'h08;
  localparam logic [7:0] COD_ADDR_STATUS   = 8'h0c;
  localparam int         COD_ADDR_W        = 8;

  // Clock option byte layout
  localparam int COD_BIT_EXT_CLK   = 0;
  localparam int COD_BIT_WAKE_SEL  = 1;
  localparam int COD_BIT_PRSC_LO   = 2;
  localparam int COD_BIT_PRSC_HI   = 3;

  // Control and status layout
  localparam int COD_BIT_HSE_EN    = 0;
  localparam int COD_BIT_READY     = 0;
  localparam int COD_BIT_SETTLING  = 1;

  // Reset values, replaced by option storage right after reset
  localparam logic [7:0] COD_RST_CLK_OPT = 8'h00;
  localparam logic [7:0] COD_RST_SETTLE  = 8'h00;

  // ****************************************************************
  // Settle count codes, counted in oscillator half cycles (edges)
  // ****************************************************************
  localparam logic [7:0]  COD_SETTLE_2048 = 8'h00;
  localparam logic [7:0]  COD_SETTLE_128  = 8'hb4;
  localparam logic [7:0]  COD_SETTLE_8    = 8'hd2;
  localparam logic [7:0]  COD_SETTLE_HALF = 8'he1;
  localparam int          COD_SCNT_W      = 13;
  localparam logic [12:0] COD_EDGES_2048  = 13'h1000;
  localparam logic [12:0] COD_EDGES_128   = 13'h0100;
  localparam logic [12:0] COD_EDGES_8     = 13'h0010;
  localparam logic [12:0] COD_EDGES_HALF  = 13'h0001;

  // ****************************************************************
  // Wake-up prescaler: quarter-cycle accumulator reaching 128 kHz
  // ****************************************************************
  localparam int         COD_ACC_W      = 10;
  localparam logic [9:0] COD_ACC_STEP   = 10'h004;
  localparam logic [9:0] COD_THR_16MHZ  = 10'h1f4;
  localparam logic [9:0] COD_THR_8MHZ   = 10'h0fa;
  localparam logic [9:0] COD_THR_4MHZ   = 10'h07d;
  localparam logic [1:0] COD_PRSC_8MHZ  = 2'h2;
  localparam logic [1:0] COD_PRSC_4MHZ  = 2'h3;

  typedef struct packed {
    logic       wakeup_clock_select;
    logic [1:0] wakeup_prescale;
    logic       ext_clock_select;
  } cod_cfg_t;

  typedef enum logic [1:0] {
    COD_ST_IDLE   = 2'b00,
    COD_ST_SETTLE = 2'b01,
    COD_ST_READY  = 2'b11
  } cod_state_t;

  function automatic cod_cfg_t cod_unpack(input logic [7:0] b);
    cod_cfg_t c;
    c.ext_clock_select    = b[COD_BIT_EXT_CLK];
    c.wakeup_clock_select = b[COD_BIT_WAKE_SEL];
    c.wakeup_prescale     = b[COD_BIT_PRSC_HI:COD_BIT_PRSC_LO];
    return c;
  endfunction

endpackage

`default_nettype wire

/* File: core/cod_settle_counter.sv */
// Purpose: Counts oscillator edges until the selected settle time passes.
// Assumes: One-cycle edge pulses from a synchronised oscillator pin.
// Notes:   Unknown codes fall back to the longest wait, the safe choice.
`default_nettype none

module cod_settle_counter
  import cod_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       osc_edge,
  input  wire logic [7:0] settle_code,
  output var  logic       ready,
  output var  logic       settling
);

  // ****************************************************************
  // Code decode
  // ****************************************************************
  function automatic logic [COD_SCNT_W-1:0] settle_edges(
    input logic [7:0] code);
    logic [COD_SCNT_W-1:0] n;
    unique case (code)
      COD_SETTLE_128:  n = COD_EDGES_128;
      COD_SETTLE_8:    n = COD_EDGES_8;
      COD_SETTLE_HALF: n = COD_EDGES_HALF;
      default:         n = COD_EDGES_2048;
    endcase
    return n;
  endfunction

  cod_state_t            state_q, state_d;
  logic [COD_SCNT_W-1:0] cnt_q,   cnt_d;
  logic [COD_SCNT_W-1:0] target;

  assign target = settle_edges(settle_code);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (!enable) begin
      state_d = COD_ST_IDLE;
      cnt_d   = '0;
    end else begin
      unique case (state_q)
        COD_ST_IDLE: begin
          state_d = COD_ST_SETTLE;
          cnt_d   = '0;
        end
        COD_ST_SETTLE: begin
          if (osc_edge) begin
            cnt_d = cnt_q + COD_SCNT_W'(1);
            if (cnt_d >= target) begin
              state_d = COD_ST_READY;
            end
          end
        end
        COD_ST_READY: begin
          state_d = COD_ST_READY;
        end
        default: begin
          state_d = COD_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= COD_ST_IDLE;
      cnt_q    <= '0;
      ready    <= 1'b0;
      settling <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      ready    <= (state_d == COD_ST_READY);
      settling <= (state_d == COD_ST_SETTLE);
    end
  end

endmodule // cod_settle_counter

`default_nettype wire

/* File: core/cod_wakeup_prescaler.sv */
// Purpose: Divides oscillator rising edges down to a 128 kHz tick.
// Assumes: One oscillator rising edge pulse per oscillator cycle.
// Notes:   A quarter-step accumulator gives exact mean rates for the
//          fractional 8 and 4 MHz ratios; single ticks jitter by a cycle.
`default_nettype none

module cod_wakeup_prescaler
  import cod_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       osc_rise,
  input  wire logic [1:0] prescale,
  output var  logic       tick
);

  logic [COD_ACC_W-1:0] acc_q, acc_d;
  logic [COD_ACC_W-1:0] thr;
  logic [COD_ACC_W-1:0] sum;
  logic                 tick_d;

  always_comb begin
    unique case (prescale)
      COD_PRSC_8MHZ: thr = COD_THR_8MHZ;
      COD_PRSC_4MHZ: thr = COD_THR_4MHZ;
      default:       thr = COD_THR_16MHZ;
    endcase
  end

  always_comb begin
    sum    = acc_q + COD_ACC_STEP;
    acc_d  = acc_q;
    tick_d = 1'b0;
    if (!run) begin
      acc_d = '0;
    end else if (osc_rise) begin
      if (sum >= thr) begin
        acc_d  = sum - thr;
        tick_d = 1'b1;
      end else begin
        acc_d = sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= '0;
      tick  <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick  <= tick_d;
    end
  end

endmodule // cod_wakeup_prescaler

`default_nettype wire

/* File: core/cod_clock_option_decoder.sv */
// Purpose: Holds the two clock option bytes, drives the oscillator pins,
//          times oscillator settling and feeds the wake-up clock.
// Assumes: APB slave with 32-bit data; option storage is on clk.
// Notes:   Option bytes are loaded from storage in the cycle after reset
//          and may then be rewritten by software.
//
// Implementation choices: the APB register port and the register offsets.
`default_nettype none

//Function
//- Crystal on both pins, or driven clock on input
//- Wake-up source: internal slow or prescaled external
//- Prescale code picks 16, 8 or 4 MHz input
//- Settle code picks 2048, 128, 8, half cycles
module cod_clock_option_decoder
  import cod_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // APB
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [COD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Option storage
  input  wire logic [7:0]            stored_clock_option,
  input  wire logic [7:0]            stored_settle_option,
  // Oscillator pins
  input  wire logic                  osc_in_pin,
  output var  logic                  osc_out_pin,
  output var  logic                  osc_out_pin_oe,
  // Slow internal oscillator, asynchronous level
  input  wire logic                  low_speed_internal_osc,
  // Clock configuration toward the clock tree
  output var  cod_pkg::cod_cfg_t     clock_cfg,
  output var  logic                  osc_ready,
  output var  logic                  osc_source_allowed,
  output var  logic                  wakeup_tick
);
  import cod_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] osc_sync_q, osc_sync_d;
  logic [2:0] lsi_sync_q, lsi_sync_d;
  logic       osc_lvl_q,  osc_lvl_d;
  logic       lsi_lvl_q,  lsi_lvl_d;
  logic       osc_edge,   osc_rise, lsi_rise;

  always_comb begin
    osc_sync_d = {osc_sync_q[1:0], osc_in_pin};
    lsi_sync_d = {lsi_sync_q[1:0], low_speed_internal_osc};
    osc_lvl_d  = osc_lvl_q;
    lsi_lvl_d  = lsi_lvl_q;
    // A change counts only once the second and third stages agree
    if (osc_sync_q[1] == osc_sync_q[2]) begin
      osc_lvl_d = osc_sync_q[2];
    end
    if (lsi_sync_q[1] == lsi_sync_q[2]) begin
      lsi_lvl_d = lsi_sync_q[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_sync_q <= '0;
      lsi_sync_q <= '0;
      osc_lvl_q  <= 1'b0;
      lsi_lvl_q  <= 1'b0;
    end else begin
      osc_sync_q <= osc_sync_d;
      lsi_sync_q <= lsi_sync_d;
      osc_lvl_q  <= osc_lvl_d;
      lsi_lvl_q  <= lsi_lvl_d;
    end
  end

  assign osc_edge = osc_lvl_d != osc_lvl_q;
  assign osc_rise = osc_lvl_d & ~osc_lvl_q;
  assign lsi_rise = lsi_lvl_d & ~lsi_lvl_q;

  // ****************************************************************
  // Option and control registers
  // ****************************************************************
  logic [7:0] clk_opt_q, clk_opt_d;
  logic [7:0] settle_q,  settle_d;
  logic       hse_en_q,  hse_en_d;
  logic       load_q,    load_d;
  logic       wr_acc,    setup;
  logic       settling;
  logic       ready_raw;
  cod_cfg_t   cfg;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign cfg    = cod_unpack(clk_opt_q);

  always_comb begin
    clk_opt_d = clk_opt_q;
    settle_d  = settle_q;
    hse_en_d  = hse_en_q;
    load_d    = 1'b0;
    if (load_q) begin
      // Storage is read after release so reset itself takes constants
      clk_opt_d = stored_clock_option;
      settle_d  = stored_settle_option;
    end else if (wr_acc && pstrb[0]) begin
      unique case (paddr)
        COD_ADDR_CLK_OPT: clk_opt_d = pwdata[7:0];
        COD_ADDR_SETTLE:  settle_d  = pwdata[7:0];
        COD_ADDR_CTRL:    hse_en_d  = pwdata[COD_BIT_HSE_EN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_opt_q <= COD_RST_CLK_OPT;
      settle_q  <= COD_RST_SETTLE;
      hse_en_q  <= 1'b0;
      load_q    <= 1'b1;
    end else begin
      clk_opt_q <= clk_opt_d;
      settle_q  <= settle_d;
      hse_en_q  <= hse_en_d;
      load_q    <= load_d;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  logic [31:0] rdata_d;
  logic        err_d;
  logic        mapped;

  always_comb begin
    rdata_d = '0;
    mapped  = 1'b1;
    unique case (paddr)
      COD_ADDR_CLK_OPT: rdata_d[7:0] = clk_opt_q;
      COD_ADDR_SETTLE:  rdata_d[7:0] = settle_q;
      COD_ADDR_CTRL:    rdata_d[COD_BIT_HSE_EN] = hse_en_q;
      COD_ADDR_STATUS: begin
        rdata_d[COD_BIT_READY]    = ready_raw;
        rdata_d[COD_BIT_SETTLING] = settling;
      end
      default:          mapped = 1'b0;
    endcase
    // Status is read-only; a write to it is refused
    err_d = ~mapped | (pwrite & (paddr == COD_ADDR_STATUS));
  end

  // Answer is prepared in the setup cycle so outputs stay registered
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & err_d;
      if (setup && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // ****************************************************************
  // Oscillator settling and wake-up prescaler
  // ****************************************************************
  logic hse_tick;

  cod_settle_counter u_settle (
    .clk         (clk),
    .rst         (rst),
    .enable      (hse_en_q),
    .osc_edge    (osc_edge),
    .settle_code (settle_q),
    .ready       (ready_raw),
    .settling    (settling)
  );

  cod_wakeup_prescaler u_prsc (
    .clk      (clk),
    .rst      (rst),
    .run      (ready_raw),
    .osc_rise (osc_rise),
    .prescale (cfg.wakeup_prescale),
    .tick     (hse_tick)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic drive_d, wake_d;

  always_comb begin
    // Crystal mode inverts the input across the pair; a driven clock
    // leaves the output pin released
    drive_d = hse_en_q & ~cfg.ext_clock_select;
    if (cfg.wakeup_clock_select) begin
      wake_d = hse_tick;
    end else begin
      wake_d = lsi_rise;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_out_pin        <= 1'b0;
      osc_out_pin_oe     <= 1'b0;
      clock_cfg          <= '0;
      osc_ready          <= 1'b0;
      osc_source_allowed <= 1'b0;
      wakeup_tick        <= 1'b0;
    end else begin
      osc_out_pin        <= drive_d & ~osc_lvl_q;
      osc_out_pin_oe     <= drive_d;
      clock_cfg          <= cfg;
      osc_ready          <= ready_raw;
      osc_source_allowed <= ready_raw & hse_en_q;
      wakeup_tick        <= wake_d;
    end
  end

endmodule // cod_clock_option_decoder

`default_nettype wire

/* File: sim/cod_clock_option_decoder_monitor.sv */
// Purpose: Port-level assertions for the clock option decoder.
// Assumes: Zero-wait APB; registered configuration outputs.
// Notes:   Bound to the top module; watches its ports only.
`default_nettype none

module cod_clock_option_decoder_monitor
  import cod_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [COD_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  low_speed_internal_osc,
  input wire logic                  osc_out_pin,
  input wire logic                  osc_out_pin_oe,
  input wire cod_pkg::cod_cfg_t     clock_cfg,
  input wire logic                  osc_ready,
  input wire logic                  osc_source_allowed,
  input wire logic                  wakeup_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic       lsi_q, lsi_d, opt_wr;
  logic [3:0] lsi_age_q, lsi_age_d, wr_q, wr_d;
  assign opt_wr = psel && penable && pready && pwrite && pstrb[0]
                  && paddr == COD_ADDR_CLK_OPT;
  always_comb begin
    lsi_d = low_speed_internal_osc;
    lsi_age_d = lsi_age_q + {3'h0, lsi_age_q != 4'hf};
    if (lsi_q != low_speed_internal_osc) lsi_age_d = 4'h0;
    wr_d = opt_wr ? pwdata[3:0] : wr_q;
  end
  always_ff @(posedge clk) begin
    lsi_q     <= lsi_d;
    lsi_age_q <= lsi_age_d;
    wr_q      <= wr_d;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence bad_access;
    apb_setup ##0 (paddr > COD_ADDR_STATUS
                   || (pwrite && paddr == COD_ADDR_STATUS));
  endsequence

  chk_apb_answer: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  chk_apb_error: assert property (bad_access |=> pslverr && pready)
    else $error("bad access not refused");
  chk_cfg_write: assert property (
    opt_wr |=> ##[0:1] clock_cfg == {wr_q[1], wr_q[3:2], wr_q[0]})
    else $error("clock config does not follow write");
  chk_ext_nodrive: assert property (
    clock_cfg.ext_clock_select [*3] |-> !osc_out_pin_oe && !osc_out_pin)
    else $error("pin driven in external clock mode");
  chk_allowed_ready: assert property (osc_source_allowed |-> osc_ready)
    else $error("source allowed before ready");
  chk_tick_pulse: assert property (wakeup_tick |=> !wakeup_tick)
    else $error("wake tick longer than a cycle");
  chk_lsi_tick: assert property (
    wakeup_tick && !clock_cfg.wakeup_clock_select
    && !$past(clock_cfg.wakeup_clock_select, 8) |-> lsi_age_q <= 4'ha)
    else $error("slow source tick without edge");
  chk_hse_tick: assert property (
    wakeup_tick && clock_cfg.wakeup_clock_select
    && $past(clock_cfg.wakeup_clock_select, 8)
    |-> osc_ready || $past(osc_ready))
    else $error("oscillator tick while not ready");
endmodule // cod_clock_option_decoder_monitor

bind cod_clock_option_decoder cod_clock_option_decoder_monitor cod_mon_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .low_speed_internal_osc(low_speed_internal_osc),
  .osc_out_pin(osc_out_pin), .osc_out_pin_oe(osc_out_pin_oe),
  .clock_cfg(clock_cfg), .osc_ready(osc_ready),
  .osc_source_allowed(osc_source_allowed), .wakeup_tick(wakeup_tick));

`default_nettype wire

/* File: sim/cod_osc_model.sv */
// Purpose: Crystal or driven clock on the oscillator input pin.
// Assumes: Called right after a rising clk edge.
// Notes:   Half period 20 ns, offset 1 ns so edges never meet clk edges.
`default_nettype none

module cod_osc_model (
  input  wire logic powered,
  output var  logic osc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial osc = 1'b0;

  // Unpowered crystal stands still, so no edge is a free gift
  task automatic make_edges(input int n);
    #1;
    repeat (n) begin
      #20;
      if (powered) osc = ~osc;
    end
  endtask
endmodule // cod_osc_model

`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the clock option decoder.
// Assumes: Zero-wait APB slave; oscillator model on the input pin.
// Notes:   Tick counts use whole accumulator periods, so residue is moot.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cod_pkg::*;

  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, osc_out_pin, osc_out_pin_oe, osc_in_pin;
  logic        osc_ready, osc_source_allowed, wakeup_tick, re;
  logic        low_speed_internal_osc = 0;
  logic [7:0]  paddr = 0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] pwdata = 0, prdata, rd;
  cod_cfg_t    clock_cfg;
  int          err_count = 0, total_checks = 0, tick_count = 0;

  cod_clock_option_decoder cod_clock_option_decoder_i (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stored_clock_option(8'h0e),
    .stored_settle_option(8'he1), .osc_in_pin(osc_in_pin),
    .osc_out_pin(osc_out_pin), .osc_out_pin_oe(osc_out_pin_oe),
    .low_speed_internal_osc(low_speed_internal_osc),
    .clock_cfg(clock_cfg), .osc_ready(osc_ready),
    .osc_source_allowed(osc_source_allowed), .wakeup_tick(wakeup_tick));
  cod_osc_model cod_osc_model_i (.osc(osc_in_pin),
    .powered(osc_out_pin_oe | clock_cfg.ext_clock_select));

  initial forever #2 clk = ~clk;
  always @(posedge clk) if (wakeup_tick === 1'b1) tick_count <= tick_count + 1;

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic check_word(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until pready is seen, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, exp, input logic err);
    int n;
    n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) check_word(0, 1, "bus hang");
    rd = prdata; re = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
    if (!w) check_word(rd, exp, "read data");
    check_word({31'h0, re}, {31'h0, err}, "bus error");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    xfer(0, COD_ADDR_CLK_OPT, 0, 32'h0e, 0);
    xfer(0, COD_ADDR_SETTLE, 0, 32'he1, 0);
    check_word({28'h0, clock_cfg}, 32'he, "decoded cfg");
    xfer(0, 8'h10, 0, 0, 1);
    xfer(1, COD_ADDR_STATUS, 1, 0, 1);
    xfer(0, COD_ADDR_CTRL, 0, 0, 0);
    pstrb <= 4'he;
    xfer(1, COD_ADDR_CLK_OPT, 32'hff, 0, 0);
    pstrb <= 4'hf;
    xfer(0, COD_ADDR_CLK_OPT, 0, 32'h0e, 0);
  endtask

  task automatic t_pins();
    xfer(1, COD_ADDR_CTRL, 1, 0, 0);
    repeat (3) @(posedge clk);
    check_word({30'h0, osc_out_pin_oe, osc_out_pin}, 3, "crystal drive");
    xfer(1, COD_ADDR_CLK_OPT, 32'h0f, 0, 0);
    repeat (3) @(posedge clk);
    check_word({30'h0, osc_out_pin_oe, osc_out_pin}, 0, "ext drive");
    xfer(1, COD_ADDR_CLK_OPT, 32'h0e, 0, 0);
  endtask

  task automatic t_settle();
    logic [7:0] code [4] = '{8'h00, 8'hb4, 8'hd2, 8'he1};
    int         edges [4] = '{4096, 256, 16, 1};
    for (int i = 0; i < 4; i++) begin
      xfer(1, COD_ADDR_CTRL, 0, 0, 0);
      xfer(1, COD_ADDR_SETTLE, {24'h0, code[i]}, 0, 0);
      xfer(1, COD_ADDR_CTRL, 1, 0, 0);
      cod_osc_model_i.make_edges(edges[i] - 1);
      repeat (12) @(posedge clk);
      xfer(0, COD_ADDR_STATUS, 0, 32'h2, 0);
      check_word({31'h0, osc_ready}, 0, "early ready");
      cod_osc_model_i.make_edges(1);
      repeat (12) @(posedge clk);
      xfer(0, COD_ADDR_STATUS, 0, 32'h1, 0);
      check_word({30'h0, osc_ready, osc_source_allowed}, 3, "ready");
    end
  endtask

  task automatic t_wake();
    int half [4] = '{250, 250, 125, 125};
    int ticks [4] = '{2, 2, 2, 4};
    int base;
    xfer(1, COD_ADDR_CLK_OPT, 32'h0c, 0, 0);
    // Count from a base so the tick counter keeps a single driver
    base = tick_count;
    repeat (4) begin
      low_speed_internal_osc <= 1;
      repeat (20) @(posedge clk);
      low_speed_internal_osc <= 0;
      repeat (20) @(posedge clk);
    end
    check_word(tick_count - base, 4, "slow ticks");
    for (int p = 0; p < 4; p++) begin
      xfer(1, COD_ADDR_CLK_OPT, {28'h0, p[1:0], 2'b10}, 0, 0);
      base = tick_count;
      cod_osc_model_i.make_edges(2 * half[p]);
      repeat (12) @(posedge clk);
      check_word(tick_count - base, ticks[p], "prescaled ticks");
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_regs();
    t_pins();
    t_settle();
    t_wake();
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
